/* rtl/uart_ctrl_pkg.sv */
package uart_ctrl_pkg;
    // Register byte addresses
    localparam logic [31:0] BUF_DIVLOW_ADDR = 32'h5000_1000;
    localparam logic [31:0] IRQ_ENABLE_DIVISOR_HIGH_ADDR = 32'h5000_1004;
    localparam logic [31:0] IRQ_IDENT_FIFO_CONTROL_ADDR = 32'h5000_1008;
    localparam logic [31:0] LINE_CTRL_ADDR = 32'h5000_100c;
    localparam logic [31:0] MODEM_CTRL_ADDR = 32'h5000_1010;

    // Reset value of every stored field
    localparam logic [7:0] REG_RESET = 8'h00;

    // Writable bits of the enable, FIFO control and modem control registers
    localparam logic [7:0] IRQ_EN_MASK = 8'h8f;
    localparam logic [7:0] FIFO_CTL_MASK = 8'hf9;
    localparam logic [7:0] MODEM_CTL_MASK = 8'h7f;

    // Interrupt-enable fields
    localparam int PROG_TX_EMPTY_BIT = 7;
    localparam int MODEM_STATUS_EN_BIT = 3;
    localparam int LINE_STATUS_EN_BIT = 2;
    localparam int TX_HOLDING_EMPTY_EN_BIT = 1;
    localparam int RX_DATA_EN_BIT = 0;

    // FIFO control fields
    localparam int RX_TRIGGER_LSB = 6;
    localparam int TX_THRESHOLD_LSB = 4;
    localparam int DMA_MODE_BIT = 3;
    localparam int TX_FLUSH_BIT = 2;
    localparam int RX_FLUSH_BIT = 1;
    localparam int FIFO_ENABLE_BIT = 0;

    // Line and modem control fields
    localparam int DIVISOR_ACCESS_BIT = 7;
    localparam int AUTO_FLOW_BIT = 5;
    localparam int RTS_CTRL_BIT = 1;

    localparam logic [1:0] FIFO_STATE_ON = 2'h3;
    localparam logic [1:0] FIFO_STATE_OFF = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Baud tick is sixteen times the bit rate
    localparam int BAUD_OVERSAMPLE = 16;

    localparam int FIFO_RX = 0;
    localparam int FIFO_TX = 1;

    typedef enum logic [3:0] {
        CAUSE_MODEM = 4'h0,
        CAUSE_NONE = 4'h1,
        CAUSE_TX_EMPTY = 4'h2,
        CAUSE_RX_DATA = 4'h4,
        CAUSE_LINE = 4'h6,
        CAUSE_BUSY = 4'h7,
        CAUSE_TIMEOUT = 4'hc
    } irq_cause_code_t;
endpackage

/* rtl/fifo_level_if.sv */
`timescale 1ns/1ps
interface fifo_level_if #(parameter int LW = 5);
    logic push;
    logic pop;
    logic flush;
    logic single;
    logic [LW-1:0] level;
    logic full;
    logic empty;
    modport ctrl(input push, pop, flush, single, output level, full, empty);
    modport user(output push, pop, flush, single, input level, full, empty);
endinterface

/* rtl/fifo_level_ctrl.sv */
`timescale 1ns/1ps
module fifo_level_ctrl #(
    parameter int DEPTH = 16
)(
    input wire logic aclk,       // System clock
    input wire logic aresetn,    // Synchronous reset, active low
    fifo_level_if.ctrl fl        // Level control and status
);
    localparam int LW = $clog2(DEPTH + 1);
    logic [LW-1:0] level_ff;
    logic [LW-1:0] nxt_level;
    logic [LW-1:0] limit;

    // Single-character buffering when the FIFOs are off
    assign limit = fl.single ? LW'(1) : LW'(DEPTH);
    assign fl.level = level_ff;
    assign fl.full = (level_ff == limit);
    assign fl.empty = (level_ff == '0);

    always_comb
    begin
        nxt_level = level_ff;
        if (fl.flush)
            nxt_level = '0;
        else if (fl.push && !fl.full && !(fl.pop && !fl.empty))
            nxt_level = level_ff + LW'(1);
        else if (fl.pop && !fl.empty && !(fl.push && !fl.full))
            nxt_level = level_ff - LW'(1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_ff <= '0;
        else
            level_ff <= nxt_level;
    end
endmodule

/* rtl/uart_irq_fifo_control.sv */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - Divisor access maps high divisor at enables
// - Enable bit 7 selects programmable empty mode
// - Enable bit 3 gates modem status, fourth
// - Enable bit 2 gates line status, first
// - Enable bit 1 gates transmit empty, third
// - Enable bit 0 gates receive and timeout
// - Shared location reads identification, writes control
// - Identification 7:6 shows FIFO enable state
// - Identification 3:0 gives top pending cause
// - Control 7:6 selects receive trigger level
// - Auto flow drops request-to-send at trigger
// - Receive DMA request uses receive trigger
// - Control 5:4 selects transmit empty threshold
// - Transmit DMA request uses transmit threshold
// - Control bit 3 selects DMA mode
// - Control bit 2 empties transmit FIFO, self-clears
// - Control bit 1 empties receive FIFO, self-clears
// - Control bit 0 enables FIFOs
// - Divisor access bit selects divisor bytes
// - Baud equals clock over sixteen times divisor
module uart_irq_fifo_control #(
    parameter int FIFO_DEPTH = 16
)(
    input wire logic aclk,                  // System clock
    input wire logic aresetn,               // Sync reset, active low
    input wire logic [31:0] s_axi_awaddr,   // Write address
    input wire logic s_axi_awvalid,         // Write address valid
    output logic s_axi_awready,             // Write address ready
    input wire logic [31:0] s_axi_wdata,    // Write data
    input wire logic [3:0] s_axi_wstrb,     // Write byte strobes
    input wire logic s_axi_wvalid,          // Write data valid
    output logic s_axi_wready,              // Write data ready
    output logic [1:0] s_axi_bresp,         // Write response
    output logic s_axi_bvalid,              // Write response valid
    input wire logic s_axi_bready,          // Write response ready
    input wire logic [31:0] s_axi_araddr,   // Read address
    input wire logic s_axi_arvalid,         // Read address valid
    output logic s_axi_arready,             // Read address ready
    output logic [31:0] s_axi_rdata,        // Read data
    output logic [1:0] s_axi_rresp,         // Read response
    output logic s_axi_rvalid,              // Read data valid
    input wire logic s_axi_rready,          // Read data ready
    input wire logic rx_char_push,          // Receiver stores a character
    input wire logic tx_char_pop,           // Transmitter takes a character
    input wire logic line_status_pending,   // Line error condition
    input wire logic modem_status_pending,  // Modem input change
    input wire logic char_timeout_pending,  // Receive timeout condition
    input wire logic busy_detect_pending,   // Write while busy
    output logic rts_n,                     // Request to send, active low
    output logic dma_rx_req_n,              // Receive DMA request, low
    output logic dma_tx_req_n,              // Transmit DMA request, low
    output logic baud16_tick                // One pulse per sixteenth bit
);
    import uart_ctrl_pkg::*;
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    function automatic logic is_mapped(input logic [31:0] addr);
        is_mapped = (addr == BUF_DIVLOW_ADDR)
            || (addr == IRQ_ENABLE_DIVISOR_HIGH_ADDR)
            || (addr == IRQ_IDENT_FIFO_CONTROL_ADDR)
            || (addr == LINE_CTRL_ADDR) || (addr == MODEM_CTRL_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // FIFO level control
    fifo_level_if #(.LW(LW)) fl [2] ();
    genvar g;
    for (g = 0; g < 2; g++)
    begin : g_fifo
        fifo_level_ctrl #(.DEPTH(FIFO_DEPTH)) u_level (
            .aclk(aclk),
            .aresetn(aresetn),
            .fl(fl[g])
        );
    end

    logic [7:0] div_low_ff, nxt_div_low;
    logic [7:0] div_high_ff, nxt_div_high;
    logic [7:0] irq_en_ff, nxt_irq_en;
    logic [7:0] fifo_ctl_ff, nxt_fifo_ctl;
    logic [7:0] line_ctl_ff, nxt_line_ctl;
    logic [7:0] modem_ctl_ff, nxt_modem_ctl;
    logic tx_push, rx_pop, tx_flush, rx_flush, tx_holding_empty_clr;
    logic divisor_access_select, fifo_enable_bit, dma_signal_mode;
    logic [1:0] rx_trigger_level, tx_empty_threshold;
    logic [LW-1:0] rx_level, tx_level, rx_trig_eff, tx_thr_eff;

    assign divisor_access_select = line_ctl_ff[DIVISOR_ACCESS_BIT];
    assign fifo_enable_bit = fifo_ctl_ff[FIFO_ENABLE_BIT];
    assign dma_signal_mode = fifo_ctl_ff[DMA_MODE_BIT];
    assign rx_trigger_level = fifo_ctl_ff[RX_TRIGGER_LSB +: 2];
    assign tx_empty_threshold = fifo_ctl_ff[TX_THRESHOLD_LSB +: 2];
    assign rx_level = fl[FIFO_RX].level;
    assign tx_level = fl[FIFO_TX].level;

    assign fl[FIFO_RX].push = rx_char_push;
    assign fl[FIFO_RX].pop = rx_pop;
    assign fl[FIFO_RX].flush = rx_flush;
    assign fl[FIFO_RX].single = !fifo_enable_bit;
    assign fl[FIFO_TX].push = tx_push;
    assign fl[FIFO_TX].pop = tx_char_pop;
    assign fl[FIFO_TX].flush = tx_flush;
    assign fl[FIFO_TX].single = !fifo_enable_bit;

    // Receive trigger: one, quarter, half, two below full
    always_comb
    begin
        unique case (rx_trigger_level)
            2'h0: rx_trig_eff = LW'(1);
            2'h1: rx_trig_eff = LW'(FIFO_DEPTH / 4);
            2'h2: rx_trig_eff = LW'(FIFO_DEPTH / 2);
            2'h3: rx_trig_eff = LW'(FIFO_DEPTH - 2);
        endcase
        if (!fifo_enable_bit)
            rx_trig_eff = LW'(1);
    end

    // Transmit threshold: empty, two, quarter, half
    always_comb
    begin
        unique case (tx_empty_threshold)
            2'h0: tx_thr_eff = '0;
            2'h1: tx_thr_eff = LW'(2);
            2'h2: tx_thr_eff = LW'(FIFO_DEPTH / 4);
            2'h3: tx_thr_eff = LW'(FIFO_DEPTH / 2);
        endcase
        if (!fifo_enable_bit)
            tx_thr_eff = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt identification
    logic tx_empty_cond, tx_holding_empty_ff, nxt_tx_holding_empty, tx_cond_d_ff;
    logic pend_line, pend_rx, pend_to, pend_tx, pend_ms;
    irq_cause_code_t cause;

    // Programmable mode only applies with FIFOs on
    assign tx_empty_cond = (irq_en_ff[PROG_TX_EMPTY_BIT] && fifo_enable_bit)
        ? (tx_level <= tx_thr_eff) : fl[FIFO_TX].empty;

    always_comb
    begin
        // New empty event wins over a same-cycle clear
        nxt_tx_holding_empty = (tx_holding_empty_ff && !tx_holding_empty_clr) || (tx_empty_cond && !tx_cond_d_ff);
        pend_line = irq_en_ff[LINE_STATUS_EN_BIT] && line_status_pending;
        pend_rx = irq_en_ff[RX_DATA_EN_BIT] && (rx_level >= rx_trig_eff);
        pend_to = irq_en_ff[RX_DATA_EN_BIT] && fifo_enable_bit
            && char_timeout_pending;
        pend_tx = irq_en_ff[TX_HOLDING_EMPTY_EN_BIT] && tx_holding_empty_ff;
        pend_ms = irq_en_ff[MODEM_STATUS_EN_BIT] && modem_status_pending;
        if (pend_line)
            cause = CAUSE_LINE;
        else if (pend_rx)
            cause = CAUSE_RX_DATA;
        else if (pend_to)
            cause = CAUSE_TIMEOUT;
        else if (pend_tx)
            cause = CAUSE_TX_EMPTY;
        else if (pend_ms)
            cause = CAUSE_MODEM;
        else if (busy_detect_pending)
            cause = CAUSE_BUSY;
        else
            cause = CAUSE_NONE;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_holding_empty_ff <= 1'b0;
            tx_cond_d_ff <= 1'b0;
        end
        else
        begin
            tx_holding_empty_ff <= nxt_tx_holding_empty;
            tx_cond_d_ff <= tx_empty_cond;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave and register file
    logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
    logic [1:0] nxt_bresp, nxt_rresp;
    logic [31:0] nxt_rdata;
    logic wr_go, ar_hs;
    logic [7:0] wb, rd_byte;

    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_go = aw_full_ff && w_full_ff && !s_axi_bvalid;
    assign wb = wdata_ff[7:0];

    always_comb
    begin
        nxt_div_low = div_low_ff;
        nxt_div_high = div_high_ff;
        nxt_irq_en = irq_en_ff;
        nxt_fifo_ctl = fifo_ctl_ff;
        nxt_line_ctl = line_ctl_ff;
        nxt_modem_ctl = modem_ctl_ff;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        tx_flush = 1'b0;
        rx_flush = 1'b0;
        tx_holding_empty_clr = 1'b0;
        rd_byte = 8'h00;
        nxt_aw_full = aw_full_ff || (s_axi_awvalid && s_axi_awready);
        nxt_w_full = w_full_ff || (s_axi_wvalid && s_axi_wready);
        nxt_awaddr = s_axi_awready ? s_axi_awaddr : awaddr_ff;
        nxt_wdata = s_axi_wready ? s_axi_wdata : wdata_ff;
        nxt_wstrb0 = s_axi_wready ? s_axi_wstrb[0] : wstrb0_ff;
        nxt_bvalid = s_axi_bvalid && !s_axi_bready;
        nxt_bresp = s_axi_bresp;
        if (wr_go)
        begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            if (wstrb0_ff)
            begin
                unique case (awaddr_ff)
                    BUF_DIVLOW_ADDR:
                        if (divisor_access_select)
                            nxt_div_low = wb;
                        else
                        begin
                            tx_push = 1'b1;
                            tx_holding_empty_clr = 1'b1;
                        end
                    IRQ_ENABLE_DIVISOR_HIGH_ADDR:
                        if (divisor_access_select)
                            nxt_div_high = wb;
                        else
                            nxt_irq_en = wb & IRQ_EN_MASK;
                    IRQ_IDENT_FIFO_CONTROL_ADDR:
                    begin
                        // Flush bits are pulses, never stored
                        nxt_fifo_ctl = wb & FIFO_CTL_MASK;
                        tx_flush = wb[TX_FLUSH_BIT];
                        rx_flush = wb[RX_FLUSH_BIT];
                        // Toggling FIFO enable drops stale contents
                        if (wb[FIFO_ENABLE_BIT] != fifo_enable_bit)
                        begin
                            tx_flush = 1'b1;
                            rx_flush = 1'b1;
                        end
                    end
                    LINE_CTRL_ADDR:
                        nxt_line_ctl = wb;
                    MODEM_CTRL_ADDR:
                        nxt_modem_ctl = wb & MODEM_CTL_MASK;
                    default:
                        nxt_line_ctl = line_ctl_ff;
                endcase
            end
        end
        nxt_awready = !nxt_aw_full && !nxt_bvalid;
        nxt_wready = !nxt_w_full && !nxt_bvalid;

        nxt_rvalid = s_axi_rvalid && !s_axi_rready;
        nxt_rdata = s_axi_rdata;
        nxt_rresp = s_axi_rresp;
        if (ar_hs)
        begin
            unique case (s_axi_araddr)
                BUF_DIVLOW_ADDR:
                    if (divisor_access_select)
                        rd_byte = div_low_ff;
                    else
                        rx_pop = 1'b1;
                IRQ_ENABLE_DIVISOR_HIGH_ADDR:
                    rd_byte = divisor_access_select
                        ? div_high_ff : irq_en_ff;
                IRQ_IDENT_FIFO_CONTROL_ADDR:
                begin
                    rd_byte = {fifo_enable_bit ? FIFO_STATE_ON
                        : FIFO_STATE_OFF, 2'h0, cause};
                    // Reading the empty cause acknowledges it
                    tx_holding_empty_clr = tx_holding_empty_clr || (cause == CAUSE_TX_EMPTY);
                end
                LINE_CTRL_ADDR:
                    rd_byte = line_ctl_ff;
                MODEM_CTRL_ADDR:
                    rd_byte = modem_ctl_ff;
                default:
                    rd_byte = 8'h00;
            endcase
            nxt_rvalid = 1'b1;
            nxt_rdata = {24'h000000, rd_byte};
            nxt_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_low_ff <= REG_RESET;
            div_high_ff <= REG_RESET;
            irq_en_ff <= REG_RESET;
            fifo_ctl_ff <= REG_RESET;
            line_ctl_ff <= REG_RESET;
            modem_ctl_ff <= REG_RESET;
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= 32'h00000000;
            wdata_ff <= 32'h00000000;
            wstrb0_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            div_low_ff <= nxt_div_low;
            div_high_ff <= nxt_div_high;
            irq_en_ff <= nxt_irq_en;
            fifo_ctl_ff <= nxt_fifo_ctl;
            line_ctl_ff <= nxt_line_ctl;
            modem_ctl_ff <= nxt_modem_ctl;
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            s_axi_awready <= nxt_awready;
            s_axi_wready <= nxt_wready;
            s_axi_bvalid <= nxt_bvalid;
            s_axi_bresp <= nxt_bresp;
            s_axi_arready <= nxt_arready;
            s_axi_rvalid <= nxt_rvalid;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flow control, DMA requests and baud divider
    logic nxt_rts_n, nxt_dma_rx_n, nxt_dma_tx_n, nxt_tick;
    logic [15:0] baud_cnt_ff, nxt_baud_cnt, divisor;

    assign divisor = {div_high_ff, div_low_ff};

    always_comb
    begin
        if (modem_ctl_ff[AUTO_FLOW_BIT] && fifo_enable_bit)
            nxt_rts_n = (rx_level >= rx_trig_eff);
        else
            nxt_rts_n = !modem_ctl_ff[RTS_CTRL_BIT];
        nxt_dma_rx_n = dma_rx_req_n;
        nxt_dma_tx_n = dma_tx_req_n;
        if (!dma_signal_mode || !fifo_enable_bit)
        begin
            nxt_dma_rx_n = fl[FIFO_RX].empty;
            nxt_dma_tx_n = !fl[FIFO_TX].empty;
        end
        else
        begin
            // Mode 1 requests hold until the FIFO is drained or filled
            if (rx_level >= rx_trig_eff)
                nxt_dma_rx_n = 1'b0;
            else if (fl[FIFO_RX].empty)
                nxt_dma_rx_n = 1'b1;
            if (tx_level <= tx_thr_eff)
                nxt_dma_tx_n = 1'b0;
            else if (fl[FIFO_TX].full)
                nxt_dma_tx_n = 1'b1;
        end
        // Divisor of zero stops the tick
        nxt_tick = 1'b0;
        nxt_baud_cnt = baud_cnt_ff + 16'h0001;
        if (divisor == 16'h0000)
            nxt_baud_cnt = 16'h0000;
        else if (nxt_baud_cnt >= divisor)
        begin
            nxt_baud_cnt = 16'h0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rts_n <= 1'b1;
            dma_rx_req_n <= 1'b1;
            dma_tx_req_n <= 1'b1;
            baud16_tick <= 1'b0;
            baud_cnt_ff <= 16'h0000;
        end
        else
        begin
            rts_n <= nxt_rts_n;
            dma_rx_req_n <= nxt_dma_rx_n;
            dma_tx_req_n <= nxt_dma_tx_n;
            baud16_tick <= nxt_tick;
            baud_cnt_ff <= nxt_baud_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_divisor_access_select_high_read: assert property (
        ar_hs && s_axi_araddr == IRQ_ENABLE_DIVISOR_HIGH_ADDR
        && divisor_access_select |=> s_axi_rdata[7:0] == $past(div_high_ff))
        else $error("divisor high byte not returned");
    chk_line_first: assert property (pend_line |-> cause == CAUSE_LINE)
        else $error("line status not top priority");
    chk_modem_rank: assert property (
        cause == CAUSE_MODEM |-> !(pend_line || pend_rx || pend_to || pend_tx))
        else $error("modem status outranked wrongly");
    chk_tx_gate: assert property (
        !irq_en_ff[TX_HOLDING_EMPTY_EN_BIT] |-> cause != CAUSE_TX_EMPTY)
        else $error("disabled transmit cause reported");
    chk_rx_gate: assert property (
        !irq_en_ff[RX_DATA_EN_BIT]
        |-> cause != CAUSE_RX_DATA && cause != CAUSE_TIMEOUT)
        else $error("disabled receive cause reported");
    chk_fifo_state: assert property (
        ar_hs && s_axi_araddr == IRQ_IDENT_FIFO_CONTROL_ADDR
        |=> s_axi_rdata[7:6] == ($past(fifo_enable_bit) ? 2'h3 : 2'h0))
        else $error("FIFO state field wrong");
    chk_none_code: assert property (
        !(pend_line || pend_rx || pend_to || pend_tx || pend_ms
        || busy_detect_pending) |-> cause == CAUSE_NONE)
        else $error("cause reported with nothing pending");
    chk_tx_flush: assert property (tx_flush |=> tx_level == '0)
        else $error("transmit FIFO not emptied");
    chk_rx_flush: assert property (rx_flush |=> rx_level == '0)
        else $error("receive FIFO not emptied");
    chk_rts_trigger: assert property (
        modem_ctl_ff[AUTO_FLOW_BIT] && fifo_enable_bit
        && rx_level >= rx_trig_eff |=> rts_n)
        else $error("request-to-send not dropped at trigger");
    chk_baud_period: assert property (
        (divisor == 16'h0003 && $stable(divisor)) [*4] ##0 baud16_tick
        |-> ##3 baud16_tick)
        else $error("baud tick period wrong");

    cov_fifo_read_ident: cover property (
        ar_hs && s_axi_araddr == IRQ_IDENT_FIFO_CONTROL_ADDR
        && fifo_enable_bit);
    cov_rx_trigger: cover property (pend_rx && rx_level > LW'(1));
    cov_dma_mode1: cover property (dma_signal_mode && !dma_rx_req_n);
    cov_tx_empty_cause: cover property (cause == CAUSE_TX_EMPTY);
endmodule

/* test/far_side.sv */
`timescale 1ns/1ps
module far_side (
    input wire logic aclk, // System clock
    output logic push      // Receiver stores a character
);
    initial push = 1'h0;
    task automatic chars(input int n);
        @(posedge aclk);
        push <= 1'h1;
        repeat (n) @(posedge aclk); // Back-to-back, one per cycle
        push <= 1'h0;
    endtask
endmodule

/* test/uart_irq_fifo_control_test.sv */
`timescale 1ns/1ps
module uart_irq_fifo_control_test;
    import uart_ctrl_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, push, line = 1'h0, rts_n, baud16_tick;
    logic tx_pop = 1'h0, modem = 1'h0, tout = 1'h0, busy = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, dma_tx_req_n;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_rx_req_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int num_errors = 0, checked = 0, ticks = 0;
    localparam logic [31:0] EN_A = IRQ_ENABLE_DIVISOR_HIGH_ADDR;
    localparam logic [31:0] ID_A = IRQ_IDENT_FIFO_CONTROL_ADDR;
    always #12.5 aclk = ~aclk;
    far_side far_side_inst (.aclk, .push);
    uart_irq_fifo_control uart_irq_fifo_control_inst (
        .*, .s_axi_wstrb(4'h1), .rx_char_push(push), .tx_char_pop(tx_pop),
        .line_status_pending(line), .modem_status_pending(modem),
        .char_timeout_pending(tout), .busy_detect_pending(busy)
    );
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, v, input logic [1:0] e = RESP_OKAY);
        logic aw_done = 1'h0;
        logic w_done = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // Each channel is released at its own handshake
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
            begin
                aw_done = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready === 1'h1)
            begin
                w_done = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (!aw_done || !w_done);
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        chk("bresp", 32'(e), 32'(s_axi_bresp));
        s_axi_bready <= 1'h0;
    endtask
    task automatic rc(input logic [31:0] a, e,
        input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", 32'(r), 32'(s_axi_rresp));
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        results();
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rc(EN_A, 32'h0);
        wr(EN_A, 32'hff);
        rc(EN_A, 32'h8f);
        wr(EN_A, 32'h4);
        wr(ID_A, 32'h41);
        line <= 1'h1;
        rc(ID_A, 32'hc6);
        wr(EN_A, 32'h1);
        $display("cause test done");
        // Line error stays pending but gated from here on
        far_side_inst.chars(3);
        rc(ID_A, 32'hc1);
        far_side_inst.chars(1);
        rc(ID_A, 32'hc4);
        wr(ID_A, 32'h43);
        rc(ID_A, 32'hc1);
        wr(ID_A, 32'h40);
        far_side_inst.chars(1);
        rc(ID_A, 32'h4);
        chk("dma_rx_req_n", 32'h0, 32'(dma_rx_req_n));
        wr(ID_A, 32'h1);
        tout <= 1'h1;
        rc(ID_A, 32'hcc);
        tout <= 1'h0;
        wr(EN_A, 32'ha);
        modem <= 1'h1;
        // Transmit empty outranks modem; reading it acknowledges it
        rc(ID_A, 32'hc2);
        rc(ID_A, 32'hc0);
        modem <= 1'h0;
        busy <= 1'h1;
        rc(ID_A, 32'hc7);
        busy <= 1'h0;
        wr(ID_A, 32'h11);
        repeat (3) wr(BUF_DIVLOW_ADDR, 32'h0);
        chk("dma_tx_req_n", 32'h1, 32'(dma_tx_req_n));
        wr(ID_A, 32'h19);
        chk("dma_tx_req_n", 32'h1, 32'(dma_tx_req_n));
        tx_pop <= 1'h1;
        @(posedge aclk);
        tx_pop <= 1'h0;
        repeat (2) @(posedge aclk);
        chk("dma_tx_req_n", 32'h0, 32'(dma_tx_req_n));
        wr(MODEM_CTRL_ADDR, 32'h20);
        @(posedge aclk);
        chk("rts_n", 32'h0, 32'(rts_n));
        far_side_inst.chars(1);
        rc(ID_A, 32'hc1);
        chk("rts_n", 32'h1, 32'(rts_n));
        $display("modem, dma and flow test done");
        wr(LINE_CTRL_ADDR, 32'h80);
        wr(EN_A, 32'h55);
        rc(EN_A, 32'h55);
        wr(32'h5000_1020, 32'h0, RESP_SLVERR);
        rc(32'h5000_1020, 32'h0, RESP_SLVERR);
        wr(BUF_DIVLOW_ADDR, 32'h3);
        wr(EN_A, 32'h0);
        // Thirty cycles of a three-cycle period hold ten ticks
        repeat (30)
        begin
            @(posedge aclk);
            ticks += int'(baud16_tick);
        end
        chk("baud16_tick", 32'ha, 32'(ticks));
        $display("fifo and divisor test done");
        results();
    end
endmodule
